/* File: core/fec_flash_controller.sv */
/*
   Flash erase controller: access mode, ready flag, page, chip, user configuration area and
   partial page erase with per-page accumulated erase time.
   Assumes a single-cycle register master on the same clock and a synchronous reset.
*/
// The plain strobed port was decided locally.
// Notes on behaviour
// - Partial erase only acts on code pages.
// - Partial start write in erase mode starts chunk.
// - Chunk length comes from duration register.
// - Accumulated time reaching full time completes page.
// - Host repeats chunks until full time covered.
// - Completed page reads all ones.
// - Flash fetches stall during any chunk.
// - Partly erased page is marked undefined.
// - Ready flag bit 0, low while busy.
// - Mode field: 0 read, 1 write, 2 erase.
// - Host enables write/erase only when needed.
// - Page address write in erase mode erases page.
// - Host never erases outside the code area.
// - Two legacy aliases act as page erase; only the OFS_PAGE_LEGACY_B alias is decoded here.
// - Chip erase on 1, nothing on 0.
// - Register starts user configuration area erase.
// - Host writes first word address of page.
// - Host sets erase mode around each chunk.
`timescale 1ns/1ps
module fec_flash_controller
   import fec_pkg::*;
#(
   parameter int          PAGES      = NUM_PAGES,
   parameter int          UNIT_CYCLES = UNIT_CYC,
   parameter logic [31:0] FULL_UNITS = FULL_PAGE_UNITS,
   parameter logic [31:0] CHIP_UNITS = CHIP_ERASE_UNITS
)(
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   fec_if.dev                              bus,
   input  wire logic [$clog2(PAGES)-1:0]   queryPage,
   output logic                            queryErased,
   output logic                            queryUndefined,
   output logic                            ucaErased,
   output logic [15:0]                     eraseCycles
);
   localparam int PG_W = $clog2(PAGES);
   localparam int UC_W = $clog2(UNIT_CYCLES + 1);
   localparam logic [UC_W-1:0] UNIT_LAST = UC_W'(UNIT_CYCLES - 1);
   localparam logic [31:0] CODE_BYTES = 32'(PAGES) << PAGE_SHIFT;

   function automatic logic inCode(input logic [31:0] a);
      inCode = a < CODE_BYTES;
   endfunction

   function automatic logic [PG_W-1:0] pageOf(input logic [31:0] a);
      pageOf = a[PAGE_SHIFT +: PG_W];
   endfunction

   fec_dev_state_t    state;
   fec_kind_t         kind;
   logic [1:0]        accessMode;
   logic              ready;
   logic [31:0]       pageReg;
   logic [31:0]       chipReg;
   logic [31:0]       legacyBReg;
   logic [31:0]       ucaReg;
   logic [31:0]       partialReg;
   logic [31:0]       durReg;
   logic [PG_W-1:0]   curPage;
   logic [31:0]       chunkUnits;
   logic [31:0]       unitsLeft;
   logic [UC_W-1:0]   unitCnt;
   logic [PAGES-1:0]  erasedMap;
   logic [PAGES-1:0]  partialMap;
   logic [31:0]       accTime [PAGES];
   logic              eraseMode;
   logic              canStart;
   logic              startPage;
   logic              startChip;
   logic              startUca;
   logic              startPart;
   logic              anyStart;
   logic              done;
   logic [31:0]       sumTime;

   always_comb begin
      eraseMode = accessMode == MODE_ERASE;
      canStart  = bus.wr && eraseMode && state == DEV_IDLE;
      startPage = canStart && (bus.addr == OFS_PAGE_ERASE || bus.addr == OFS_PAGE_LEGACY_B)
                  && inCode(bus.wdata);
      startChip = canStart && bus.addr == OFS_CHIP_ERASE && bus.wdata[CMD_BIT];
      startUca  = canStart && bus.addr == OFS_UCA_ERASE && bus.wdata[CMD_BIT];
      startPart = canStart && bus.addr == OFS_PARTIAL_START && inCode(bus.wdata);
      anyStart  = startPage || startChip || startUca || startPart;
      done      = state == DEV_ERASE && unitsLeft == 32'h0000_0000;
      sumTime   = accTime[curPage] + chunkUnits;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         accessMode <= MODE_READ;
         pageReg    <= 32'h0000_0000;
         chipReg    <= 32'h0000_0000;
         legacyBReg <= 32'h0000_0000;
         ucaReg     <= 32'h0000_0000;
         partialReg <= 32'h0000_0000;
         durReg     <= DUR_RESET;
      end else if (bus.wr) begin
         if (bus.addr == OFS_CONFIG) begin
            accessMode <= bus.wdata[1:0];
         end else if (bus.addr == OFS_PAGE_ERASE) begin
            pageReg <= bus.wdata;
         end else if (bus.addr == OFS_CHIP_ERASE) begin
            chipReg <= bus.wdata;
         end else if (bus.addr == OFS_PAGE_LEGACY_B) begin
            legacyBReg <= bus.wdata;
         end else if (bus.addr == OFS_UCA_ERASE) begin
            ucaReg <= bus.wdata;
         end else if (bus.addr == OFS_PARTIAL_START) begin
            partialReg <= bus.wdata;
         end else if (bus.addr == OFS_PARTIAL_DUR) begin
            durReg <= bus.wdata;
         end
      end
   end

   // Operation sequencer; the unit counter paces the erase in fixed time units.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state      <= DEV_IDLE;
         kind       <= KIND_PAGE;
         curPage    <= '0;
         chunkUnits <= 32'h0000_0000;
         unitsLeft  <= 32'h0000_0000;
         unitCnt    <= '0;
      end else if (anyStart) begin
         state   <= DEV_ERASE;
         unitCnt <= '0;
         curPage <= pageOf(bus.wdata);
         if (startPart) begin
            kind       <= KIND_PARTIAL;
            unitsLeft  <= durReg;
            chunkUnits <= durReg;
         end else if (startChip) begin
            kind      <= KIND_CHIP;
            unitsLeft <= CHIP_UNITS;
         end else if (startUca) begin
            kind      <= KIND_UCA;
            unitsLeft <= FULL_UNITS;
         end else begin
            kind      <= KIND_PAGE;
            unitsLeft <= FULL_UNITS;
         end
      end else if (done) begin
         state <= DEV_IDLE;
      end else if (state == DEV_ERASE) begin
         if (unitCnt == UNIT_LAST) begin
            unitCnt   <= '0;
            unitsLeft <= unitsLeft - 32'h0000_0001;
         end else begin
            unitCnt <= unitCnt + UC_W'(1);
         end
      end
   end

   // Ready flag and fetch stall share one cause.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ready          <= READY_RESET[READY_BIT];
         bus.fetchStall <= 1'b0;
      end else if (anyStart) begin
         ready          <= 1'b0;
         bus.fetchStall <= 1'b1;
      end else if (done) begin
         ready          <= 1'b1;
         bus.fetchStall <= 1'b0;
      end
   end

   // Per-page erase state and accumulated erase time.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         erasedMap   <= '0;
         partialMap  <= '0;
         ucaErased   <= 1'b0;
         eraseCycles <= 16'h0000;
         for (int i = 0; i < PAGES; i++) begin
            accTime[i] <= 32'h0000_0000;
         end
      end else if (anyStart) begin
         if (startPart) begin
            erasedMap[pageOf(bus.wdata)]  <= 1'b0;
            partialMap[pageOf(bus.wdata)] <= 1'b1;
         end else if (startPage) begin
            erasedMap[pageOf(bus.wdata)] <= 1'b0;
         end else if (startUca) begin
            ucaErased <= 1'b0;
         end
      end else if (done) begin
         if (kind == KIND_PARTIAL) begin
            if (sumTime >= FULL_UNITS) begin
               erasedMap[curPage]  <= 1'b1;
               partialMap[curPage] <= 1'b0;
               accTime[curPage]    <= sumTime - FULL_UNITS;
               eraseCycles         <= eraseCycles + 16'h0001;
            end else begin
               accTime[curPage] <= sumTime;
            end
         end else if (kind == KIND_PAGE) begin
            erasedMap[curPage]  <= 1'b1;
            partialMap[curPage] <= 1'b0;
            accTime[curPage]    <= 32'h0000_0000;
            eraseCycles         <= eraseCycles + 16'h0001;
         end else if (kind == KIND_CHIP) begin
            erasedMap  <= '1;
            partialMap <= '0;
            ucaErased  <= 1'b1;
            for (int i = 0; i < PAGES; i++) begin
               accTime[i] <= 32'h0000_0000;
            end
         end else begin
            ucaErased <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         queryErased    <= 1'b0;
         queryUndefined <= 1'b0;
      end else begin
         queryErased    <= erasedMap[queryPage];
         queryUndefined <= partialMap[queryPage];
      end
   end

   // Register read port; unmapped offsets read zero.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus.rdata <= 32'h0000_0000;
      end else if (bus.rd) begin
         if (bus.addr == OFS_READY) begin
            bus.rdata <= {31'h0000_0000, ready};
         end else if (bus.addr == OFS_CONFIG) begin
            bus.rdata <= {30'h0000_0000, accessMode};
         end else if (bus.addr == OFS_PAGE_ERASE) begin
            bus.rdata <= pageReg;
         end else if (bus.addr == OFS_CHIP_ERASE) begin
            bus.rdata <= chipReg;
         end else if (bus.addr == OFS_PAGE_LEGACY_B) begin
            bus.rdata <= legacyBReg;
         end else if (bus.addr == OFS_UCA_ERASE) begin
            bus.rdata <= ucaReg;
         end else if (bus.addr == OFS_PARTIAL_START) begin
            bus.rdata <= partialReg;
         end else if (bus.addr == OFS_PARTIAL_DUR) begin
            bus.rdata <= durReg;
         end else begin
            bus.rdata <= 32'h0000_0000;
         end
      end
   end
endmodule

/* File: core/fec_pkg.sv */
/*
   Shared constants and types of the flash erase controller and its processor-side master.
   Assumes one 250 MHz clock and a synchronous active-high reset in both ends.
*/
package fec_pkg;
   localparam int          ADDR_W            = 12;
   localparam int          DATA_W            = 32;
   localparam logic [11:0] OFS_READY         = 12'h400;
   localparam logic [11:0] OFS_CONFIG        = 12'h504;
   localparam logic [11:0] OFS_PAGE_ERASE    = 12'h508;
   localparam logic [11:0] OFS_CHIP_ERASE    = 12'h50C;
   localparam logic [11:0] OFS_PAGE_LEGACY_B = 12'h510;
   localparam logic [11:0] OFS_UCA_ERASE     = 12'h514;
   localparam logic [11:0] OFS_PARTIAL_START = 12'h518;
   localparam logic [11:0] OFS_PARTIAL_DUR   = 12'h51C;
   localparam logic [31:0] READY_RESET       = 32'h0000_0001;
   localparam logic [1:0]  MODE_READ         = 2'h0;
   localparam logic [1:0]  MODE_WRITE        = 2'h1;
   localparam logic [1:0]  MODE_ERASE        = 2'h2;
   localparam int          READY_BIT         = 0;
   localparam int          CMD_BIT           = 0;
   localparam int          PAGE_SHIFT        = 12;
   localparam int          NUM_PAGES         = 16;
   localparam int          CLK_PERIOD_NS     = 4;
   localparam int          UNIT_TIME_NS      = 1000;
   localparam int          UNIT_CYC          = (UNIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] FULL_PAGE_UNITS   = 32'h0000_0055;
   localparam logic [31:0] CHIP_ERASE_UNITS  = 32'h0000_00AA;
   localparam logic [31:0] DUR_RESET         = 32'h0000_000A;
   localparam logic [11:0] HOST_OFS_PAGE     = 12'h000;
   localparam logic [11:0] HOST_OFS_DUR      = 12'h004;
   localparam logic [11:0] HOST_OFS_STATUS   = 12'h008;
   localparam logic [11:0] HOST_OFS_FULL     = 12'h00C;
   localparam logic [11:0] HOST_OFS_CHUNKS   = 12'h010;

   typedef enum logic [0:0] {
      DEV_IDLE  = 1'b0,
      DEV_ERASE = 1'b1
   } fec_dev_state_t;

   typedef enum logic [1:0] {
      KIND_PAGE    = 2'b00,
      KIND_CHIP    = 2'b01,
      KIND_UCA     = 2'b10,
      KIND_PARTIAL = 2'b11
   } fec_kind_t;

   typedef enum logic [2:0] {
      HST_IDLE  = 3'b000,
      HST_DUR   = 3'b001,
      HST_EEN   = 3'b010,
      HST_START = 3'b011,
      HST_POLL  = 3'b100,
      HST_CHECK = 3'b101,
      HST_REN   = 3'b110
   } fec_host_state_t;
endpackage

/* File: core/fec_if.sv */
/*
   Register bus and fetch-stall level between the processor-side master and the flash controller.
   Assumes both ends share one clock; the testbench joins them.
*/
`timescale 1ns/1ps
interface fec_if;
   import fec_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   logic              fetchStall;

   modport dev (input addr, input wdata, input wr, input rd, output rdata, output fetchStall);
   modport cpu (output addr, output wdata, output wr, output rd, input rdata, input fetchStall);
endinterface

/* File: core/fec_host_ctrl.sv */
/*
   Processor-side master: runs a whole partial page erase as repeated chunks and offers its own
   small register port to software.
   Assumes the flash controller on the other side of the interface, same clock, synchronous reset.
*/
`timescale 1ns/1ps
module fec_host_ctrl
   import fec_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   fec_if.cpu                       bus,
   input  wire logic [ADDR_W-1:0]   swAddr,
   input  wire logic [DATA_W-1:0]   swWdata,
   input  wire logic                swWr,
   input  wire logic                swRd,
   output logic [DATA_W-1:0]        swRdata
);
   fec_host_state_t state;
   logic [31:0]     pageAddr;
   logic [31:0]     durUnits;
   logic [31:0]     fullUnits;
   logic [31:0]     accUnits;
   logic [15:0]     chunks;
   logic            doneFlag;
   logic            rejected;
   logic            launch;

   always_comb begin
      launch = swWr && swAddr == HOST_OFS_PAGE && state == HST_IDLE;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pageAddr  <= 32'h0000_0000;
         durUnits  <= DUR_RESET;
         fullUnits <= FULL_PAGE_UNITS;
      end else if (swWr && state == HST_IDLE) begin
         if (swAddr == HOST_OFS_PAGE) begin
            pageAddr <= {swWdata[31:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}};
         end else if (swAddr == HOST_OFS_DUR) begin
            durUnits <= swWdata;
         end else if (swAddr == HOST_OFS_FULL) begin
            fullUnits <= swWdata;
         end
      end
   end

   // Chunk sequencer: every chunk is bracketed by erase mode and a return to read only.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state     <= HST_IDLE;
         accUnits  <= 32'h0000_0000;
         chunks    <= 16'h0000;
         doneFlag  <= 1'b0;
         rejected  <= 1'b0;
         bus.addr  <= '0;
         bus.wdata <= 32'h0000_0000;
         bus.wr    <= 1'b0;
         bus.rd    <= 1'b0;
      end else begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         case (state)
            HST_IDLE: begin
               if (launch) begin
                  doneFlag <= 1'b0;
                  accUnits <= 32'h0000_0000;
                  chunks   <= 16'h0000;
                  if ({swWdata[31:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}} < (32'(NUM_PAGES) << PAGE_SHIFT)
                      && durUnits != 32'h0000_0000) begin
                     rejected <= 1'b0;
                     state    <= HST_DUR;
                  end else begin
                     rejected <= 1'b1;
                  end
               end
            end
            HST_DUR: begin
               bus.addr  <= OFS_PARTIAL_DUR;
               bus.wdata <= durUnits;
               bus.wr    <= 1'b1;
               state     <= HST_EEN;
            end
            HST_EEN: begin
               bus.addr  <= OFS_CONFIG;
               bus.wdata <= {30'h0000_0000, MODE_ERASE};
               bus.wr    <= 1'b1;
               state     <= HST_START;
            end
            HST_START: begin
               bus.addr  <= OFS_PARTIAL_START;
               bus.wdata <= pageAddr;
               bus.wr    <= 1'b1;
               state     <= HST_POLL;
            end
            HST_POLL: begin
               if (bus.rd) begin
                  state <= HST_CHECK;
               end else begin
                  bus.addr <= OFS_READY;
                  bus.rd   <= 1'b1;
               end
            end
            HST_CHECK: begin
               if (bus.rdata[READY_BIT]) begin
                  state <= HST_REN;
               end else begin
                  state <= HST_POLL;
               end
            end
            HST_REN: begin
               bus.addr  <= OFS_CONFIG;
               bus.wdata <= {30'h0000_0000, MODE_READ};
               bus.wr    <= 1'b1;
               accUnits  <= accUnits + durUnits;
               chunks    <= chunks + 16'h0001;
               if (accUnits + durUnits >= fullUnits) begin
                  doneFlag <= 1'b1;
                  state    <= HST_IDLE;
               end else begin
                  state <= HST_EEN;
               end
            end
            default: begin
               state <= HST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         swRdata <= 32'h0000_0000;
      end else if (swRd) begin
         if (swAddr == HOST_OFS_PAGE) begin
            swRdata <= pageAddr;
         end else if (swAddr == HOST_OFS_DUR) begin
            swRdata <= durUnits;
         end else if (swAddr == HOST_OFS_STATUS) begin
            swRdata <= {28'h0000_000, bus.fetchStall, rejected, doneFlag, state != HST_IDLE};
         end else if (swAddr == HOST_OFS_FULL) begin
            swRdata <= fullUnits;
         end else if (swAddr == HOST_OFS_CHUNKS) begin
            swRdata <= {16'h0000, chunks};
         end else begin
            swRdata <= 32'h0000_0000;
         end
      end
   end
endmodule

/* File: dv/fec_bus_monitor.sv */
/*
   Assertion checker for the bus between the host master and the flash controller.
   Assumes the bench instantiates it beside the interface that joins the two ends.
*/
`timescale 1ns/1ps
module fec_bus_monitor
   import fec_pkg::*;
#(
   parameter int UNIT_CYCLES = UNIT_CYC
)(
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic              fetchStall
);
   logic [1:0]  mode;
   logic [31:0] dur;
   logic [31:0] stallCnt;
   logic        start;

   assign start = wr && addr == OFS_PARTIAL_START;

   // Shadow copies of the mode and duration registers.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode <= MODE_READ;
         dur  <= DUR_RESET;
      end else if (wr && addr == OFS_CONFIG) begin
         mode <= wdata[1:0];
      end else if (wr && addr == OFS_PARTIAL_DUR) begin
         dur <= wdata;
      end
   end

   // Counts the cycles of the current stall.
   always_ff @(posedge core_clk) begin
      if (rst || !fetchStall) begin
         stallCnt <= '0;
      end else begin
         stallCnt <= stallCnt + 32'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_ready_read;
      rd && addr == OFS_READY |=> rdata == {31'h0, !$past(fetchStall)};
   endproperty
   a_ready_read: assert property (p_ready_read) else $error("ready read wrong");
   property p_start_stalls;
      start && mode == MODE_ERASE && !fetchStall && wdata < (NUM_PAGES << PAGE_SHIFT) |=> fetchStall;
   endproperty
   a_start_stalls: assert property (p_start_stalls) else $error("chunk did not start");
   property p_chunk_len;
      $fell(fetchStall) |-> stallCnt == dur * UNIT_CYCLES + 1;
   endproperty
   a_chunk_len: assert property (p_chunk_len) else $error("chunk length wrong");
   property p_stall_cause;
      $rose(fetchStall) |-> $past(start);
   endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("stall without start");
   property p_mode_before;
      start |-> mode == MODE_ERASE && dur != 32'h0;
   endproperty
   a_mode_before: assert property (p_mode_before) else $error("start outside erase mode");
   property p_aligned;
      start |-> wdata[11:0] == 12'h000 && wdata < (NUM_PAGES << PAGE_SHIFT);
   endproperty
   a_aligned: assert property (p_aligned) else $error("start address not a code page");
   property p_poll;
      start |=> rd && addr == OFS_READY;
   endproperty
   a_poll: assert property (p_poll) else $error("no ready poll after start");
   property p_back_read;
      $fell(fetchStall) |-> ##[1:8] (wr && addr == OFS_CONFIG && wdata[1:0] == MODE_READ);
   endproperty
   a_back_read: assert property (p_back_read) else $error("mode not returned to read");
endmodule

/* File: dv/flash_erase_write_controller_bench.sv */
/*
   Bench: host master and controller joined by one interface, plus a second controller
   driven straight from the bench. Assumes package, interface and design files come first.
*/
`timescale 1ns/1ps
module flash_erase_write_controller_bench;
   import fec_pkg::*;
   localparam int UC = 2;
   localparam int FU = 4;
   localparam int CU = 6;
   logic              core_clk;
   logic              rst;
   logic [ADDR_W-1:0] swAddr;
   logic [DATA_W-1:0] swWdata;
   logic              swWr;
   logic              swRd;
   logic [DATA_W-1:0] swRdata;
   logic [3:0]        qPage;
   logic              erasedA, undefA, ucaA, erasedB, undefB, ucaB, pendSw, pendB;
   logic [15:0]       cycA, cycB;
   logic [63:0]       qSw[$], qB[$];
   logic [11:0]       ofsT[5] = '{OFS_PAGE_ERASE, OFS_PAGE_LEGACY_B, OFS_CHIP_ERASE, OFS_UCA_ERASE, OFS_PARTIAL_START};
   logic [31:0]       valT[5] = '{32'h2000, 32'h5000, 32'h1, 32'h1, 32'h3000};
   int                error_cnt, total_checks, n, d, p;

   fec_if busA();
   fec_if busB();
   fec_host_ctrl fec_host_ctrl_i (.core_clk(core_clk), .rst(rst), .bus(busA.cpu), .swAddr(swAddr),
      .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
   fec_flash_controller #(.UNIT_CYCLES(UC), .FULL_UNITS(32'h4), .CHIP_UNITS(32'h6)) fec_flash_controller_i (
      .core_clk(core_clk), .rst(rst), .bus(busA.dev), .queryPage(qPage), .queryErased(erasedA),
      .queryUndefined(undefA), .ucaErased(ucaA), .eraseCycles(cycA));
   fec_flash_controller #(.UNIT_CYCLES(UC), .FULL_UNITS(32'h4), .CHIP_UNITS(32'h6)) fec_flash_controller_solo_i (
      .core_clk(core_clk), .rst(rst), .bus(busB.dev), .queryPage(qPage), .queryErased(erasedB),
      .queryUndefined(undefB), .ucaErased(ucaB), .eraseCycles(cycB));
   fec_bus_monitor #(.UNIT_CYCLES(UC)) fec_bus_monitor_i (.core_clk(core_clk), .rst(rst), .addr(busA.addr),
      .wdata(busA.wdata), .wr(busA.wr), .rd(busA.rd), .rdata(busA.rdata), .fetchStall(busA.fetchStall));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [63:0] e);
      total_checks++;
      if ((got & e[31:0]) !== e[63:32]) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, e[63:32]);
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      cmp(got, {e, 32'hFFFF_FFFF});
   endtask

   // Read results are compared in the cycle after the strobe, oldest note first.
   always @(posedge core_clk) begin
      pendSw <= swRd;
      pendB  <= busB.rd;
   end
   always @(negedge core_clk) begin
      if (pendSw) cmp(swRdata, qSw.pop_front());
      if (pendB) cmp(busB.rdata, qB.pop_front());
   end

   task automatic wrB(input logic [11:0] a, input logic [31:0] v);
      @(posedge core_clk);
      busB.addr  <= a;
      busB.wdata <= v;
      busB.wr    <= 1'b1;
      @(posedge core_clk);
      busB.wr <= 1'b0;
   endtask

   task automatic rdB(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      qB.push_back({e, m});
      @(posedge core_clk);
      busB.addr <= a;
      busB.rd   <= 1'b1;
      @(posedge core_clk);
      busB.rd <= 1'b0;
   endtask

   task automatic swW(input logic [11:0] a, input logic [31:0] v);
      @(posedge core_clk);
      swAddr  <= a;
      swWdata <= v;
      swWr    <= 1'b1;
      @(posedge core_clk);
      swWr <= 1'b0;
   endtask

   task automatic swR(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      qSw.push_back({e, m});
      @(posedge core_clk);
      swAddr <= a;
      swRd   <= 1'b1;
      @(posedge core_clk);
      swRd <= 1'b0;
   endtask

   // Writes an erase register, reads ready at once and measures the busy time.
   task automatic eraseB(input logic [11:0] a, input logic [31:0] v, input int u);
      wrB(a, v);
      rdB(OFS_READY, (u == 0) ? 32'h1 : 32'h0, 32'hFFFF_FFFF);
      n = 2;
      #1;
      while (u != 0 && busB.fetchStall === 1'b1 && n < 2000) begin
         n++;
         @(posedge core_clk);
         #1;
      end
      if (u != 0) chk(n, u * UC + 1);
      if (n >= 2000) report_and_stop();
   endtask

   task automatic partialB(input logic [31:0] v, input int u);
      wrB(OFS_PARTIAL_DUR, u);
      wrB(OFS_CONFIG, 32'(MODE_ERASE));
      eraseB(OFS_PARTIAL_START, v, u);
      wrB(OFS_CONFIG, 32'(MODE_READ));
   endtask

   task automatic peek(input logic [3:0] pg);
      @(posedge core_clk);
      qPage <= pg;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   // Starts a host sequence and waits until its bus has been quiet for 8 cycles.
   task automatic hostRun(input int pg, input int dv);
      int q;
      q = 0;
      swW(HOST_OFS_DUR, 32'(dv));
      swW(HOST_OFS_PAGE, 32'(pg) << PAGE_SHIFT);
      for (int i = 0; i < 20000 && q < 8; i++) begin
         @(posedge core_clk);
         #1;
         q = (busA.wr || busA.rd || busA.fetchStall) ? 0 : q + 1;
      end
      if (q < 8) begin
         error_cnt++;
         $display("mismatch at %0t: host sequence timed out", $time);
         report_and_stop();
      end
   endtask

   initial begin
      rst = 1'b1;
      swAddr = '0;
      swWdata = '0;
      swWr = 1'b0;
      swRd = 1'b0;
      qPage = '0;
      busB.addr = '0;
      busB.wdata = '0;
      busB.wr = 1'b0;
      busB.rd = 1'b0;
      error_cnt = 0;
      total_checks = 0;
      void'($urandom(41));
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rdB(OFS_READY, READY_RESET, 32'hFFFF_FFFF);
      rdB(OFS_CONFIG, 32'h0, 32'h3);
      rdB(OFS_PARTIAL_DUR, DUR_RESET, 32'hFFFF_FFFF);
      rdB(12'h600, 32'h0, 32'hFFFF_FFFF);
      $display("test reset values done");
      wrB(OFS_CONFIG, 32'(MODE_WRITE));
      rdB(OFS_CONFIG, 32'(MODE_WRITE), 32'h3);
      for (int i = 0; i < 5; i++) eraseB(ofsT[i], valT[i], 0);
      peek(4'h2);
      chk(erasedB, 1'b0);
      chk(ucaB, 1'b0);
      $display("test refused erases done");
      wrB(OFS_CONFIG, 32'(MODE_ERASE));
      eraseB(OFS_UCA_ERASE, 32'h1, FU);
      chk(ucaB, 1'b1);
      eraseB(OFS_PAGE_ERASE, 32'h2000, FU);
      eraseB(OFS_PAGE_LEGACY_B, 32'h5000, FU);
      eraseB(OFS_PARTIAL_START, 32'h10000, 0);
      eraseB(OFS_CHIP_ERASE, 32'h0, 0);
      wrB(OFS_CONFIG, 32'(MODE_READ));
      peek(4'h2);
      chk(erasedB, 1'b1);
      peek(4'h5);
      chk(erasedB, 1'b1);
      chk(cycB, 32'h2);
      $display("test erase kinds done");
      partialB(32'h3000, 1);
      peek(4'h3);
      chk(erasedB, 1'b0);
      chk(undefB, 1'b1);
      partialB(32'h3000, 3);
      peek(4'h3);
      chk(erasedB, 1'b1);
      chk(undefB, 1'b0);
      chk(cycB, 32'h3);
      $display("test direct partial erase done");
      swW(HOST_OFS_FULL, 32'(FU));
      p = $urandom % 8;
      for (int k = 0; k < 2; k++) begin
         d = 1 + $urandom % 3;
         hostRun(p + 8 * k, d);
         swR(HOST_OFS_STATUS, 32'h2, 32'hF);
         swR(HOST_OFS_CHUNKS, 32'((FU + d - 1) / d), 32'hFFFF_FFFF);
         peek(4'(p + 8 * k));
         chk(erasedA, 1'b1);
         chk(undefA, 1'b0);
         chk(cycA, 32'(k + 1));
      end
      hostRun(16, 2);
      swR(HOST_OFS_STATUS, 32'h4, 32'h4);
      chk(cycA, 32'h2);
      chk(ucaA, 1'b0);
      $display("test host partial erase done");
      rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      peek(4'h9);
      chk(cycB, 32'h0);
      chk(erasedB, 1'b0);
      wrB(OFS_CONFIG, 32'(MODE_ERASE));
      eraseB(OFS_CHIP_ERASE, 32'h1, CU);
      wrB(OFS_CONFIG, 32'(MODE_READ));
      peek(4'h9);
      chk(erasedB, 1'b1);
      chk(ucaB, 1'b1);
      chk(cycB, 32'h0);
      $display("test chip erase after reset done");
      report_and_stop();
   end
endmodule
